// ===== shared/pdfs_regs.svh
// Offsets, field layout, reset values and pin masks of the port D upper pin selector.
// Assumes a 16-bit register port with byte offsets on an 8-bit address.
`ifndef PDFS_REGS_SVH
`define PDFS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PDFS_OFS_FUNC_SEL 8'h00
`define PDFS_OFS_DIRECTION 8'h02
`define PDFS_OFS_PIN_LEVEL 8'h04
`define PDFS_OFS_EFF_FUNC 8'h06

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define PDFS_FIELD_W 2
`define PDFS_NPINS 8
`define PDFS_DIR_LSB 8
`define PDFS_FUNC_SEL_RST 16'h0000
`define PDFS_DIRECTION_RST 8'h00
`define PDFS_CODE_GPIO 2'h0
`define PDFS_CODE_BUS 2'h1
`define PDFS_CODE_ALT2 2'h2
`define PDFS_CODE_ALT3 2'h3

// ----------------------------------------------------------------
// Per-pin properties, bit i is pin 24+i
// ----------------------------------------------------------------
// Alternate function 2 always drives (transmit data, motor outputs)
`define PDFS_ALT2_OUT_MASK 8'h47
// Alternate function 2 follows the direction bit (serial clock)
`define PDFS_ALT2_DIR_MASK 8'h20
// Alternate function 3 exists (timer capture/compare); reserved elsewhere
`define PDFS_ALT3_VALID_MASK 8'hf8
// Idle levels fed to unselected peripheral inputs; receive data idles high
`define PDFS_ALT2_IDLE 8'h80
`define PDFS_ALT3_IDLE 8'h00

`endif

// ===== shared/pdfs_pkg.sv
// Types of the port D upper pin selector.
// Assumes nothing beyond the SystemVerilog package scope.
package pdfs_pkg;

  // ----------------------------------------------------------------
  // Effective pin function
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FN_GPIO = 2'b00,
    FN_BUS = 2'b01,
    FN_ALT2 = 2'b10,
    FN_ALT3 = 2'b11
  } pdfs_fn_e;

  // ----------------------------------------------------------------
  // State of the top module apart from the reset synchronizer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] func_sel;
    logic [7:0] direction;
    logic [15:0] rdata;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] gpio_in;
    logic [7:0] db_in;
    logic [7:0] alt2_in;
    logic [7:0] alt3_in;
  } pdfs_state_s;

endpackage

// ===== shared/pdfs_mux_if.sv
// Carrier between the selector's register/flop top and its routing matrix.
// Assumes both ends sit in one clock domain; all signals but select and direction are combinational.
interface pdfs_mux_if;
  logic [15:0] func_sel;
  logic [7:0] direction;
  logic single_chip;
  logic rom_dis_bus32;
  logic [7:0] pin_in;
  logic [7:0] gpio_out;
  logic [7:0] db_out;
  logic db_oe;
  logic [7:0] alt2_out;
  logic [7:0] alt3_out;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] db_in;
  logic [7:0] alt2_in;
  logic [7:0] alt3_in;
  logic [15:0] eff_func;

  modport ctl (
    output func_sel, direction, single_chip, rom_dis_bus32, pin_in,
    output gpio_out, db_out, db_oe, alt2_out, alt3_out,
    input pin_out, pin_oe, db_in, alt2_in, alt3_in, eff_func
  );
  modport mux (
    input func_sel, direction, single_chip, rom_dis_bus32, pin_in,
    input gpio_out, db_out, db_oe, alt2_out, alt3_out,
    output pin_out, pin_oe, db_in, alt2_in, alt3_in, eff_func
  );
endinterface

// ===== rtl/pdfs_pin_mux.sv
// Routing matrix of the port D upper pins: decode select codes and steer each pin.
// Assumes registered select and direction values arrive through the carrier.
`include "pdfs_regs.svh"
module pdfs_pin_mux (
  // Carrier to the top
  pdfs_mux_if.mux m
);

  // Per-pin masks as named constants so that each slice can pick its own bit
  localparam logic [7:0] alt2_out_mask = `PDFS_ALT2_OUT_MASK;
  localparam logic [7:0] alt2_dir_mask = `PDFS_ALT2_DIR_MASK;
  localparam logic [7:0] alt3_valid_mask = `PDFS_ALT3_VALID_MASK;
  localparam logic [7:0] alt2_idle = `PDFS_ALT2_IDLE;
  localparam logic [7:0] alt3_idle = `PDFS_ALT3_IDLE;

  // ----------------------------------------------------------------
  // One slice per pin
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `PDFS_NPINS; i = i + 1) begin : g_pin
      logic [1:0] code;
      pdfs_pkg::pdfs_fn_e fn;
      logic alt2_oe;
      logic alt3_oe;

      assign code = m.func_sel[`PDFS_FIELD_W*i +: `PDFS_FIELD_W];

      // Operating mode overrides codes 00 and 01 only
      always_comb begin
        case (code)
          `PDFS_CODE_GPIO: fn = m.rom_dis_bus32 ? pdfs_pkg::FN_BUS : pdfs_pkg::FN_GPIO; // [RL11]
          `PDFS_CODE_BUS: fn = m.single_chip ? pdfs_pkg::FN_GPIO : pdfs_pkg::FN_BUS; // [RL12]
          `PDFS_CODE_ALT2: fn = pdfs_pkg::FN_ALT2;
          default: fn = pdfs_pkg::FN_ALT3;
        endcase
      end

      assign alt2_oe = alt2_out_mask[i] | (alt2_dir_mask[i] & m.direction[i]); // [RL14]
      // Reserved code on pins 26..24 leaves the pin undriven rather than guessing
      assign alt3_oe = alt3_valid_mask[i] & m.direction[i]; // [RL14] [RL9]

      // Routing per pin 24+i [RL1] [RL2] [RL3] [RL4] [RL5] [RL6] [RL7] [RL8]
      always_comb begin
        case (fn)
          pdfs_pkg::FN_GPIO: begin
            m.pin_out[i] = m.gpio_out[i];
            m.pin_oe[i] = m.direction[i]; // [RL14]
          end
          pdfs_pkg::FN_BUS: begin
            m.pin_out[i] = m.db_out[i];
            m.pin_oe[i] = m.db_oe;
          end
          pdfs_pkg::FN_ALT2: begin
            m.pin_out[i] = m.alt2_out[i];
            m.pin_oe[i] = alt2_oe;
          end
          default: begin
            m.pin_out[i] = m.alt3_out[i];
            m.pin_oe[i] = alt3_oe;
          end
        endcase
      end

      // Unselected peripherals see their idle level [RL15]
      assign m.db_in[i] = (fn == pdfs_pkg::FN_BUS) ? m.pin_in[i] : 1'h0;
      assign m.alt2_in[i] = (fn == pdfs_pkg::FN_ALT2) ? m.pin_in[i] : alt2_idle[i];
      assign m.alt3_in[i] = (fn == pdfs_pkg::FN_ALT3 && alt3_valid_mask[i]) ?
                            m.pin_in[i] : alt3_idle[i];
      assign m.eff_func[`PDFS_FIELD_W*i +: `PDFS_FIELD_W] = fn;
    end
  endgenerate

endmodule

// ===== rtl/pdfs_top.sv
// Pin-function selector for port D pins 31..24 with its select and direction registers.
// Assumes synchronous pin inputs, a 16-bit register port and static mode straps.
//
// Contract
// RL1: Pin 31 codes: GPIO, bus bit 31, serial 2 receive, timer 5 A.
// RL2: Pin 30 codes: GPIO, bus bit 30, serial 2 transmit, timer 4 B.
// RL3: Pin 29 codes: GPIO, bus bit 29, serial 2 clock, timer 4 A.
// RL4: Pin 28 codes: GPIO, bus bit 28, timer clock B, timer 3 D.
// RL5: Pin 27 codes: GPIO, bus bit 27, timer clock A, timer 3 C.
// RL6: Pin 26 codes: GPIO, bus bit 26, motor PWM W-phase output B.
// RL7: Pin 25 codes: GPIO, bus bit 25, motor PWM V-phase output B.
// RL8: Pin 24 codes: GPIO, bus bit 24, motor PWM U-phase output B.
// RL9: Software never writes code 11 for pins 26, 25 and 24.
// RL10: All select fields reset to 00, every pin starts as GPIO.
// RL11: ROM disabled with 32-bit area zero bus: code 00 means bus bit.
// RL12: Single-chip mode: code 01 means GPIO instead of bus bit.
// RL13: Only power-on reset clears select register; other resets leave it.
// RL14: GPIO, serial clock and timer pins drive when direction bit is 1.
// RL15: Unselected peripheral inputs see idle levels; only selected function drives pin.
`include "pdfs_regs.svh"
module pdfs_top (
  // Clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Operating mode
  input wire logic SINGLE_CHIP_MODE,
  input wire logic ROM_DIS_BUS32_MODE,
  // Pins, bit i is pin 24+i
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE,
  // General I/O port data
  input wire logic [7:0] GPIO_OUT,
  output logic [7:0] GPIO_IN,
  // External data bus bits 31..24
  input wire logic [7:0] DB_OUT,
  input wire logic DB_OE,
  output logic [7:0] DB_IN,
  // Serial channel 2
  output logic SERIAL2_RECEIVE_IN,
  input wire logic SERIAL2_TRANSMIT_OUT,
  input wire logic SERIAL2_CLOCK_IO_OUT,
  output logic SERIAL2_CLOCK_IO_IN,
  // Timer pulse unit
  output logic TIMER_EXT_CLOCK_A,
  output logic TIMER_EXT_CLOCK_B,
  input wire logic TIMER_CH5_CAPCOMP_A_OUT,
  output logic TIMER_CH5_CAPCOMP_A_IN,
  input wire logic TIMER_CH4_CAPCOMP_B_OUT,
  output logic TIMER_CH4_CAPCOMP_B_IN,
  input wire logic TIMER_CH4_CAPCOMP_A_OUT,
  output logic TIMER_CH4_CAPCOMP_A_IN,
  input wire logic TIMER_CH3_CAPCOMP_D_OUT,
  output logic TIMER_CH3_CAPCOMP_D_IN,
  input wire logic TIMER_CH3_CAPCOMP_C_OUT,
  output logic TIMER_CH3_CAPCOMP_C_IN,
  // Motor PWM timer
  input wire logic MOTOR_PWM_W_OUT_B,
  input wire logic MOTOR_PWM_V_OUT_B,
  input wire logic MOTOR_PWM_U_OUT_B
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n;

  // RSTN is the external power-on reset; nothing else clears this block [RL13]
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync_ff <= 2'h0;
    end else if (CE) begin
      rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pdfs_pkg::pdfs_state_s state_ff;
  pdfs_pkg::pdfs_state_s nxt_state;
  pdfs_mux_if mux_if ();

  // ----------------------------------------------------------------
  // Routing matrix
  // ----------------------------------------------------------------
  assign mux_if.func_sel = state_ff.func_sel;
  assign mux_if.direction = state_ff.direction;
  assign mux_if.single_chip = SINGLE_CHIP_MODE;
  assign mux_if.rom_dis_bus32 = ROM_DIS_BUS32_MODE;
  assign mux_if.pin_in = PIN_IN;
  assign mux_if.gpio_out = GPIO_OUT;
  assign mux_if.db_out = DB_OUT;
  assign mux_if.db_oe = DB_OE;
  // Bit slots of unused functions are zero; the matrix never enables the pin for them
  assign mux_if.alt2_out = {1'h0, SERIAL2_TRANSMIT_OUT, SERIAL2_CLOCK_IO_OUT, 2'h0,
                            MOTOR_PWM_W_OUT_B, MOTOR_PWM_V_OUT_B, MOTOR_PWM_U_OUT_B};
  assign mux_if.alt3_out = {TIMER_CH5_CAPCOMP_A_OUT, TIMER_CH4_CAPCOMP_B_OUT,
                            TIMER_CH4_CAPCOMP_A_OUT, TIMER_CH3_CAPCOMP_D_OUT,
                            TIMER_CH3_CAPCOMP_C_OUT, 3'h0};

  pdfs_pin_mux u_pin_mux (
    .m (mux_if.mux)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic wr_sel;
  logic wr_dir;

  assign wr_sel = WR && (ADDR == `PDFS_OFS_FUNC_SEL);
  assign wr_dir = WR && (ADDR == `PDFS_OFS_DIRECTION);

  always_comb begin
    nxt_state = state_ff;
    // Select and direction are plain storage; code 11 on the motor pins is taken as written
    if (wr_sel) begin
      nxt_state.func_sel = WDATA; // [RL1] [RL2] [RL3] [RL4] [RL5] [RL6] [RL7] [RL8]
    end
    if (wr_dir) begin
      nxt_state.direction = WDATA[`PDFS_DIR_LSB +: `PDFS_NPINS]; // [RL14]
    end
    // Read data stand for the one cycle after the strobe only
    nxt_state.rdata = 16'h0000;
    if (RD) begin
      case (ADDR)
        `PDFS_OFS_FUNC_SEL: nxt_state.rdata = state_ff.func_sel;
        `PDFS_OFS_DIRECTION: nxt_state.rdata = {state_ff.direction, 8'h00};
        `PDFS_OFS_PIN_LEVEL: nxt_state.rdata = {8'h00, state_ff.gpio_in};
        `PDFS_OFS_EFF_FUNC: nxt_state.rdata = mux_if.eff_func;
        default: nxt_state.rdata = 16'h0000;
      endcase
    end
    // Registering pin paths costs a cycle but keeps every output glitch free
    nxt_state.pin_out = mux_if.pin_out;
    nxt_state.pin_oe = mux_if.pin_oe; // [RL15]
    nxt_state.gpio_in = PIN_IN;
    nxt_state.db_in = mux_if.db_in;
    nxt_state.alt2_in = mux_if.alt2_in; // [RL15]
    nxt_state.alt3_in = mux_if.alt3_in; // [RL15]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_ff.func_sel <= `PDFS_FUNC_SEL_RST; // [RL10] [RL13]
      state_ff.direction <= `PDFS_DIRECTION_RST;
      state_ff.rdata <= 16'h0000;
      state_ff.pin_out <= 8'h00;
      state_ff.pin_oe <= 8'h00;
      state_ff.gpio_in <= 8'h00;
      state_ff.db_in <= 8'h00;
      state_ff.alt2_in <= `PDFS_ALT2_IDLE; // [RL15]
      state_ff.alt3_in <= `PDFS_ALT3_IDLE;
    end else if (CE) begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RDATA = state_ff.rdata;
  assign PIN_OUT = state_ff.pin_out;
  assign PIN_OE = state_ff.pin_oe;
  assign GPIO_IN = state_ff.gpio_in;
  assign DB_IN = state_ff.db_in;
  assign SERIAL2_RECEIVE_IN = state_ff.alt2_in[7];
  assign SERIAL2_CLOCK_IO_IN = state_ff.alt2_in[5];
  assign TIMER_EXT_CLOCK_B = state_ff.alt2_in[4];
  assign TIMER_EXT_CLOCK_A = state_ff.alt2_in[3];
  assign TIMER_CH5_CAPCOMP_A_IN = state_ff.alt3_in[7];
  assign TIMER_CH4_CAPCOMP_B_IN = state_ff.alt3_in[6];
  assign TIMER_CH4_CAPCOMP_A_IN = state_ff.alt3_in[5];
  assign TIMER_CH3_CAPCOMP_D_IN = state_ff.alt3_in[4];
  assign TIMER_CH3_CAPCOMP_C_IN = state_ff.alt3_in[3];

endmodule

// ===== tb/pdfs_pin_model.sv
// Board-side model of port D pins 31..24 for the selector bench.
// Assumes the bench sets the board level of every pad the selector releases.
module pdfs_pin_model (
  // Selector side
  input wire logic [7:0] drv_out,
  input wire logic [7:0] drv_oe,
  // Board side
  input wire logic [7:0] ext,
  output logic [7:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pad shows the board level, never the last driven value
  assign pad = (drv_oe & drv_out) | (~drv_oe & ext);
endmodule

// ===== tb/pdfs_top_assertions.sv
// Checker of the port D upper pin selector, watching only its top ports.
// Assumes the writable registers change only through the port; CE low freezes all.
module pdfs_top_assertions (
  // Clock, reset and register port
  input wire logic SYS_CLK, RSTN, CE, WR, RD,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA, RDATA,
  // Modes, pins and peripheral sides
  input wire logic SINGLE_CHIP_MODE, ROM_DIS_BUS32_MODE, DB_OE,
  input wire logic SERIAL2_RECEIVE_IN, SERIAL2_TRANSMIT_OUT,
  input wire logic [7:0] PIN_IN, PIN_OUT, PIN_OE, GPIO_OUT, DB_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sel_ff;
  logic [7:0] dir_ff;
  logic [2:0] live_ff;
  logic up;
  // Stays low until the internal reset copy has drained
  assign up = live_ff[2] & CE;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sel_ff <= 16'h0000;
      dir_ff <= 8'h00;
      live_ff <= 3'h0;
    end else if (CE) begin
      live_ff <= {live_ff[1:0], 1'h1};
      if (WR && ADDR == 8'h00) sel_ff <= WDATA;
      if (WR && ADDR == 8'h02) dir_ff <= WDATA[15:8];
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  sequence s_rd_sel; up && RD && ADDR == 8'h00; endsequence
  sequence s_sel_then_zero;
    RDATA == $past(sel_ff) ##1 (RDATA == 16'h0000 || $past(RD));
  endsequence
  property p_rd_sel; s_rd_sel |=> s_sel_then_zero; endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("select readback wrong");
  property p_rst;
    disable iff (1'h0) !RSTN && $past(!RSTN)
      |-> PIN_OE == 8'h00 && RDATA == 16'h0000 && SERIAL2_RECEIVE_IN;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset level");
  property p_rx_idle; up && sel_ff[15:14] != 2'h2 |=> SERIAL2_RECEIVE_IN; endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("receive input not idle");
  property p_rx_route;
    up && sel_ff[15:14] == 2'h2 |=> SERIAL2_RECEIVE_IN == $past(PIN_IN[7]);
  endproperty
  a_rx_route: assert property (p_rx_route) else $error("receive not routed");
  property p_tx;
    up && sel_ff[13:12] == 2'h2 |=> PIN_OE[6] && PIN_OUT[6] == $past(SERIAL2_TRANSMIT_OUT);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit not on pin");
  property p_gpio;
    up && !ROM_DIS_BUS32_MODE && sel_ff[1:0] == 2'h0 |=> PIN_OE[0] == $past(dir_ff[0])
      && (!PIN_OE[0] || PIN_OUT[0] == $past(GPIO_OUT[0]));
  endproperty
  a_gpio: assert property (p_gpio) else $error("port pin drive wrong");
  property p_bus_rom;
    up && ROM_DIS_BUS32_MODE && sel_ff[9:8] == 2'h0 |=> PIN_OE[4] == $past(DB_OE)
      && DB_IN[4] == $past(PIN_IN[4]);
  endproperty
  a_bus_rom: assert property (p_bus_rom) else $error("code 00 not bus");
  property p_single;
    up && SINGLE_CHIP_MODE && sel_ff[7:6] == 2'h1 |=> PIN_OE[3] == $past(dir_ff[3])
      && !DB_IN[3];
  endproperty
  a_single: assert property (p_single) else $error("code 01 not port");
  property p_resv; up && sel_ff[5:4] == 2'h3 |=> !PIN_OE[2]; endproperty
  a_resv: assert property (p_resv) else $error("reserved code drives");
endmodule
bind pdfs_top pdfs_top_assertions u_chk (
  .SYS_CLK, .RSTN, .CE, .WR, .RD, .ADDR, .WDATA, .RDATA, .SINGLE_CHIP_MODE,
  .ROM_DIS_BUS32_MODE, .DB_OE, .SERIAL2_RECEIVE_IN, .SERIAL2_TRANSMIT_OUT,
  .PIN_IN, .PIN_OUT, .PIN_OE, .GPIO_OUT, .DB_IN
);

// ===== tb/pdfs_top_test.sv
// Bench of the port D upper pin selector: registers, routing codes and modes.
// Assumes the pin model closes the pads; peripheral outputs share one vector.
module pdfs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, ce, wr_s, rd_s, db_oe, single, romdis;
  logic [7:0] addr, gpo, dbo, po, ext;
  logic [15:0] wdata;
  wire [15:0] rdata;
  wire [7:0] pin_in, pin_out, pin_oe, gpio_in, db_in, a2i, a3i;
  int n_mismatch = 0;
  int samples_checked = 0;
  pdfs_top DUT (
    .SYS_CLK(clk), .RSTN(rstn), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .SINGLE_CHIP_MODE(single), .ROM_DIS_BUS32_MODE(romdis),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .GPIO_OUT(gpo), .GPIO_IN(gpio_in),
    .DB_OUT(dbo), .DB_OE(db_oe), .DB_IN(db_in), .SERIAL2_RECEIVE_IN(a2i[7]),
    .SERIAL2_TRANSMIT_OUT(po[6]), .SERIAL2_CLOCK_IO_OUT(po[5]), .SERIAL2_CLOCK_IO_IN(a2i[5]),
    .TIMER_EXT_CLOCK_A(a2i[3]), .TIMER_EXT_CLOCK_B(a2i[4]),
    // Timer outputs carry the inverse so that a swapped alt2/alt3 route shows
    .TIMER_CH5_CAPCOMP_A_OUT(~po[7]), .TIMER_CH5_CAPCOMP_A_IN(a3i[7]),
    .TIMER_CH4_CAPCOMP_B_OUT(~po[6]), .TIMER_CH4_CAPCOMP_B_IN(a3i[6]),
    .TIMER_CH4_CAPCOMP_A_OUT(~po[5]), .TIMER_CH4_CAPCOMP_A_IN(a3i[5]),
    .TIMER_CH3_CAPCOMP_D_OUT(~po[4]), .TIMER_CH3_CAPCOMP_D_IN(a3i[4]),
    .TIMER_CH3_CAPCOMP_C_OUT(~po[3]), .TIMER_CH3_CAPCOMP_C_IN(a3i[3]),
    .MOTOR_PWM_W_OUT_B(po[2]), .MOTOR_PWM_V_OUT_B(po[1]), .MOTOR_PWM_U_OUT_B(po[0])
  );
  pdfs_pin_model u_pins (.drv_out(pin_out), .drv_oe(pin_oe), .ext(ext), .pad(pin_in));
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp16({8'h00, got}, {8'h00, exp});
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge clk);
    wr_s <= 1'h0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clk);
    rd_s <= 1'h0;
    #1 cmp16(rdata, exp);
  endtask
  // Pads loop back through the model, so allow one cycle more than the routing
  task automatic cfg(input logic [15:0] sel, input logic [7:0] dir);
    reg_wr(8'h00, sel);
    reg_wr(8'h02, {dir, 8'h00});
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic t_reset_gpio;
    reg_rd(8'h00, 16'h0000);
    cmp8(a2i & 8'hb8, 8'h80);
    cmp8(gpio_in, ext);
    cfg(16'h0000, 8'h0f);
    cmp8(pin_oe, 8'h0f);
    cmp8(gpio_in, {ext[7:4], gpo[3:0]});
    reg_rd(8'h02, 16'h0f00);
  endtask
  task automatic t_alt;
    cfg(16'haaaa, 8'h00);
    cmp8(pin_oe, 8'h47);
    cmp8(pin_out & 8'h47, po & 8'h47);
    cmp8(a2i & 8'hb8, ext & 8'hb8);
    cmp8(a3i & 8'hf8, 8'h00);
    cfg(16'haaaa, 8'h20);
    cmp8(pin_oe, 8'h67);
    cfg(16'hffff, 8'h00);
    cmp8(a3i & 8'hf8, ext & 8'hf8);
    cmp8(a2i & 8'hb8, 8'h80);
    cfg(16'hffff, 8'hff);
    cmp8(pin_oe, 8'hf8);
    cmp8(pin_out & 8'hf8, ~po & 8'hf8);
    reg_rd(8'h00, 16'hffff);
    reg_rd(8'h08, 16'h0000);
  endtask
  task automatic t_bus_modes;
    cfg(16'h5555, 8'h00);
    cmp8(db_in, ext);
    @(posedge clk);
    db_oe <= 1'h1;
    romdis <= 1'h1;
    cfg(16'h0000, 8'h00);
    cmp8(pin_out, dbo);
    reg_rd(8'h06, 16'h5555);
    @(posedge clk);
    romdis <= 1'h0;
    single <= 1'h1;
    cfg(16'h5555, 8'hff);
    cmp8(pin_out, gpo);
    cmp8(db_in, 8'h00);
    @(posedge clk);
    single <= 1'h0;
  endtask
  // Clock enable low: a write is ignored and the pin paths hold their last value
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'h0;
    dbo <= 8'h69;
    reg_wr(8'h00, 16'h0000);
    repeat (2) @(posedge clk);
    #1 cmp8(pin_out, 8'h96);
    @(posedge clk);
    ce <= 1'h1;
    reg_rd(8'h00, 16'h5555);
    repeat (2) @(posedge clk);
    #1 cmp8(pin_out, 8'h69);
  endtask
  task automatic t_reset_again;
    @(posedge clk);
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    reg_rd(8'h00, 16'h0000);
    reg_rd(8'h02, 16'h0000);
  endtask
  task automatic give_verdict;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {rstn, wr_s, rd_s, db_oe, single, romdis} = 6'h00;
    ce = 1'h1;
    {addr, wdata} = 24'h000000;
    {gpo, dbo, po, ext} = 32'hc396a53a;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    t_reset_gpio();
    t_alt();
    t_bus_modes();
    t_freeze();
    t_reset_again();
    give_verdict();
  end
endmodule
